// ===== pkg/vtedh_pkg.sv
package vtedh_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] VTEDH_CTRL_ADDR = 8'h00;
    localparam logic [7:0] VTEDH_STATUS_ADDR = 8'h04;
    localparam logic [7:0] VTEDH_IN_FLAGS_ADDR = 8'h08;
    localparam logic [7:0] VTEDH_OUT_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] VTEDH_OVR_SEL_ADDR = 8'h10;
    localparam logic [7:0] VTEDH_OVR_VAL_ADDR = 8'h14;
    localparam logic [7:0] VTEDH_RSV_IN_BASE = 8'h40;
    localparam logic [7:0] VTEDH_RSV_OUT_BASE = 8'h60;

    // ----------------------------------------
    // Control field positions and reset value
    // ----------------------------------------
    localparam int VTEDH_CTRL_BLANK_LEN = 0;
    localparam int VTEDH_CTRL_IN_LATCH = 1;
    localparam int VTEDH_CTRL_OUT_LATCH = 2;
    localparam int VTEDH_CTRL_RSV_OVR = 3;
    localparam logic [3:0] VTEDH_CTRL_RESET = 4'h1;

    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int VTEDH_STAT_FIELD_LSB = 0;
    localparam int VTEDH_STAT_TIMING_REF_ERROR = 3;
    localparam int VTEDH_STAT_COMPOSITE = 4;

    // ----------------------------------------
    // Widths and standard codes
    // ----------------------------------------
    localparam int VTEDH_NFLAGS = 15;
    localparam int VTEDH_NRSV = 7;
    localparam int VTEDH_IN_W = 17;
    localparam int VTEDH_OUT_W = 16;
    localparam logic [3:0] VTEDH_STD_NTSC_CMP = 4'h1;
    localparam logic [3:0] VTEDH_STD_PAL_CMP = 4'h5;

    // ----------------------------------------
    // Timing reference word counts (last word index)
    // ----------------------------------------
    localparam logic [2:0] VTEDH_TRS_LAST_COMPONENT = 3'h3;
    localparam logic [2:0] VTEDH_TRS_LAST_COMPOSITE = 3'h4;

    // ----------------------------------------
    // Vertical blanking lines and samples
    // ----------------------------------------
    localparam logic [9:0] VTEDH_NC_RISE1 = 10'h001;
    localparam logic [9:0] VTEDH_NC_RISE2 = 10'h108;
    localparam logic [9:0] VTEDH_NC_END1_S = 10'h009;
    localparam logic [9:0] VTEDH_NC_END2_S = 10'h110;
    localparam logic [9:0] VTEDH_NC_END1_L = 10'h013;
    localparam logic [9:0] VTEDH_NC_END2_L = 10'h11A;
    localparam logic [9:0] VTEDH_PC_RISE1 = 10'h270;
    localparam logic [9:0] VTEDH_PC_RISE2 = 10'h137;
    localparam logic [9:0] VTEDH_PC_END1 = 10'h016;
    localparam logic [9:0] VTEDH_PC_END2 = 10'h14F;
    localparam logic [9:0] VTEDH_NX_START1 = 10'h20D;
    localparam logic [11:0] VTEDH_NX_SAMP1 = 12'h300;
    localparam logic [9:0] VTEDH_NX_START2 = 10'h107;
    localparam logic [11:0] VTEDH_NX_SAMP2 = 12'h139;
    localparam logic [11:0] VTEDH_NX_END_SAMP = 12'h2FF;
    localparam logic [9:0] VTEDH_PX_START1 = 10'h26F;
    localparam logic [11:0] VTEDH_PX_SAMP1 = 12'h17E;
    localparam logic [9:0] VTEDH_PX_START2 = 10'h136;
    localparam logic [11:0] VTEDH_PX_SAMP2 = 12'h3B4;
    localparam logic [9:0] VTEDH_PX_END1_S = 10'h005;
    localparam logic [9:0] VTEDH_PX_END2_S = 10'h13D;
    localparam logic [9:0] VTEDH_PX_END1_L = 10'h00F;
    localparam logic [9:0] VTEDH_PX_END2_L = 10'h147;
    localparam logic [11:0] VTEDH_PX_END_SAMP = 12'h3B3;
endpackage : vtedh_pkg

// ===== pkg/vtedh_sticky_if.sv
`timescale 1ns/1ns
`default_nettype none
interface vtedh_sticky_if #(parameter int W = 16);
    logic update;
    logic [W-1:0] sample;
    logic latch_en;
    logic rd_clr;
    logic [W-1:0] held;
    modport core (output update, output sample, output latch_en, output rd_clr, input held);
    modport store (input update, input sample, input latch_en, input rd_clr, output held);
endinterface : vtedh_sticky_if
`default_nettype wire

// ===== src/vtedh_sticky.sv
`timescale 1ns/1ns
`default_nettype none
module vtedh_sticky #(parameter int W = 16) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Flag group
    vtedh_sticky_if.store fl
);
    // ----------------------------------------
    // Held flags
    // ----------------------------------------
    logic [W-1:0] next_held;
    logic [W-1:0] kept;

    // Latched: read clears, new events merge so they win over the clear
    assign kept = (fl.latch_en && !fl.rd_clr) ? fl.held : '0;
    assign next_held = fl.latch_en ? (kept | (fl.update ? fl.sample : '0)) :
                       (fl.update ? fl.sample : fl.held);
    // Flag register
    always_ff @(posedge clk) begin
        if (reset) begin
            fl.held <= '0;
        end else if (ce) begin
            fl.held <= next_held;
        end
    end
endmodule : vtedh_sticky
`default_nettype wire

// ===== src/vtedh_rsv_store.sv
`timescale 1ns/1ns
`default_nettype none
module vtedh_rsv_store (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Host side
    input wire logic host_wr,
    input wire logic [2:0] host_idx,
    input wire logic [9:0] host_wdata,
    output logic [9:0] host_in_word,
    output logic [9:0] host_out_word,
    // Incoming packet capture
    input wire logic in_valid,
    input wire logic [2:0] in_idx,
    input wire logic [9:0] in_word,
    // Outgoing packet selection
    input wire logic override,
    input wire logic [2:0] out_idx,
    input wire logic [9:0] out_pass,
    output logic [9:0] out_word
);
    // ----------------------------------------
    // Word storage
    // ----------------------------------------
    logic [9:0] in_mem [0:6];
    logic [9:0] out_mem [0:6];
    logic in_ok;
    logic out_ok;
    logic host_ok;

    assign in_ok = in_idx < 3'h7;
    assign out_ok = out_idx < 3'h7;
    assign host_ok = host_idx < 3'h7;
    assign host_in_word = host_ok ? in_mem[host_idx] : 10'h000;
    assign host_out_word = host_ok ? out_mem[host_idx] : 10'h000;
    assign out_word = (override && out_ok) ? out_mem[out_idx] : out_pass;
    // Received reserved words, kept for host reads
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 7; i++) in_mem[i] <= 10'h000;
        end else if (ce && in_valid && in_ok) begin
            in_mem[in_idx] <= in_word;
        end
    end

    // Host-written replacement words
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 7; i++) out_mem[i] <= 10'h000;
        end else if (ce && host_wr && host_ok) begin
            out_mem[host_idx] <= host_wdata;
        end
    end
endmodule : vtedh_rsv_store
`default_nettype wire

// ===== src/vtedh_top.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module vtedh_top (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Standard and straps
    input wire logic [3:0] standard_code,
    input wire logic blanking_length_select,
    input wire logic reset_position_select,
    // Flywheel position and outgoing TRS marks
    input wire logic [2:0] fly_field,
    input wire logic [9:0] fly_line,
    input wire logic [11:0] fly_sample,
    input wire logic out_trs_start,
    input wire logic out_trs_eav,
    // Timing reference compare
    input wire logic fly_trs_due,
    input wire logic [9:0] fly_trs_id,
    input wire logic rx_trs_seen,
    input wire logic [9:0] rx_trs_id,
    // Incoming EDH packet
    input wire logic edh_in_strobe,
    input wire logic [14:0] edh_in_flags,
    input wire logic edh_in_ffv,
    input wire logic edh_in_apv,
    input wire logic edh_in_rsv_valid,
    input wire logic [2:0] edh_in_rsv_idx,
    input wire logic [9:0] edh_in_rsv_word,
    // Outgoing EDH packet
    input wire logic edh_out_strobe,
    input wire logic [14:0] edh_calc_flags,
    input wire logic edh_calc_chksm_err,
    input wire logic [2:0] edh_out_rsv_idx,
    input wire logic [9:0] edh_out_rsv_pass,
    // Timing outputs
    output logic [2:0] field_id,
    output logic frame_blanking_flag,
    output logic line_blank_flag,
    output logic timing_ref_error,
    output logic line_store_reset_n,
    // EDH outputs
    output logic [14:0] edh_out_flags,
    output logic [9:0] edh_out_rsv_word,
    output logic edh_interrupt
);
    import vtedh_pkg::*;

    // ----------------------------------------
    // Shared decode functions
    // ----------------------------------------
    // Inclusive line/sample window, wrapping past the frame end
    function automatic logic in_region(input logic [9:0] ln, input logic [11:0] sm,
                                       input logic [9:0] l0, input logic [11:0] s0,
                                       input logic [9:0] l1, input logic [11:0] s1);
        logic after_start;
        logic before_end;
        after_start = (ln > l0) || ((ln == l0) && (sm >= s0));
        before_end = (ln < l1) || ((ln == l1) && (sm <= s1));
        in_region = (l0 > l1) ? (after_start || before_end) : (after_start && before_end);
    endfunction : in_region

    // Host address to reserved word index
    function automatic logic [2:0] rsv_index(input logic [7:0] a);
        rsv_index = a[4:2];
    endfunction : rsv_index

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [3:0] ctrl;
    logic [14:0] ovr_sel;
    logic [14:0] ovr_val;

    // ----------------------------------------
    // Standard classification
    // ----------------------------------------
    logic composite;
    logic is_pal;
    logic long_sel;

    assign composite = (standard_code == VTEDH_STD_NTSC_CMP) || (standard_code == VTEDH_STD_PAL_CMP);
    assign is_pal = standard_code[2];
    assign long_sel = blanking_length_select & ctrl[VTEDH_CTRL_BLANK_LEN];

    // ----------------------------------------
    // Outgoing timing reference word tracking
    // ----------------------------------------
    logic in_trs;
    logic [2:0] wpos;
    logic is_eav;
    logic hb;
    logic [2:0] last_pos;
    logic cur_in;
    logic [2:0] cur_pos;
    logic cur_eav;
    logic id_word;

    assign last_pos = composite ? VTEDH_TRS_LAST_COMPOSITE : VTEDH_TRS_LAST_COMPONENT;
    assign cur_in = out_trs_start || (in_trs && (wpos < last_pos));
    assign cur_pos = out_trs_start ? 3'h0 : 3'(wpos + 3'h1);
    assign cur_eav = out_trs_start ? out_trs_eav : is_eav;
    assign id_word = cur_in && (cur_pos == last_pos);

    // Word position within the current reference
    always_ff @(posedge clk) begin
        if (reset) begin
            in_trs <= 1'b0;
            wpos <= 3'h0;
            is_eav <= 1'b0;
        end else if (ce) begin
            in_trs <= cur_in;
            wpos <= cur_pos;
            is_eav <= cur_eav;
        end
    end

    // ----------------------------------------
    // Line blanking
    // ----------------------------------------
    logic next_hb;
    logic next_line_blank;

    assign next_hb = (cur_in && cur_eav) ? 1'b1 : ((id_word && !cur_eav) ? 1'b0 : hb);
    assign next_line_blank = composite ? cur_in :
                             (hb || (cur_in && cur_eav));

    // Horizontal blanking state and output
    always_ff @(posedge clk) begin
        if (reset) begin
            hb <= 1'b0;
            line_blank_flag <= 1'b0;
        end else if (ce) begin
            hb <= next_hb;
            line_blank_flag <= next_line_blank;
        end
    end

    // ----------------------------------------
    // Frame blanking
    // ----------------------------------------
    logic [9:0] nc_end1;
    logic [9:0] nc_end2;
    logic [9:0] px_end1;
    logic [9:0] px_end2;
    logic comp_win;
    logic ntsc_cmp_win;
    logic pal_cmp_win;
    logic next_frame_blank;

    assign nc_end1 = long_sel ? VTEDH_NC_END1_S : VTEDH_NC_END1_L;
    assign nc_end2 = long_sel ? VTEDH_NC_END2_S : VTEDH_NC_END2_L;
    assign px_end1 = long_sel ? VTEDH_PX_END1_S : VTEDH_PX_END1_L;
    assign px_end2 = long_sel ? VTEDH_PX_END2_S : VTEDH_PX_END2_L;
    // Component: high from rise line, low from end line onward
    assign comp_win = is_pal ?
        (in_region(fly_line, 12'h000, VTEDH_PC_RISE1, 12'h000, 10'(VTEDH_PC_END1 - 10'h001), 12'h000) ||
         in_region(fly_line, 12'h000, VTEDH_PC_RISE2, 12'h000, 10'(VTEDH_PC_END2 - 10'h001), 12'h000)) :
        (in_region(fly_line, 12'h000, VTEDH_NC_RISE1, 12'h000, 10'(nc_end1 - 10'h001), 12'h000) ||
         in_region(fly_line, 12'h000, VTEDH_NC_RISE2, 12'h000, 10'(nc_end2 - 10'h001), 12'h000));
    assign ntsc_cmp_win =
        in_region(fly_line, fly_sample, VTEDH_NX_START1, VTEDH_NX_SAMP1, nc_end1, VTEDH_NX_END_SAMP) ||
        in_region(fly_line, fly_sample, VTEDH_NX_START2, VTEDH_NX_SAMP2, nc_end2, VTEDH_NX_END_SAMP);
    assign pal_cmp_win =
        in_region(fly_line, fly_sample, VTEDH_PX_START1, VTEDH_PX_SAMP1, px_end1, VTEDH_PX_END_SAMP) ||
        in_region(fly_line, fly_sample, VTEDH_PX_START2, VTEDH_PX_SAMP2, px_end2, VTEDH_PX_END_SAMP);
    // Component changes only at the EAV; composite follows every sample
    assign next_frame_blank = composite ? (is_pal ? pal_cmp_win : ntsc_cmp_win) :
                              ((out_trs_start && out_trs_eav) ? comp_win : frame_blanking_flag);

    // Frame blanking and field outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            frame_blanking_flag <= 1'b1;
            field_id <= 3'h0;
        end else if (ce) begin
            frame_blanking_flag <= next_frame_blank;
            field_id <= composite ? fly_field : {2'h0, fly_field[0]};
        end
    end

    // ----------------------------------------
    // Timing reference error
    // ----------------------------------------
    logic trs_bad;
    logic trs_good;

    // Missing, misplaced, or wrong ID; valid only with flywheel on
    assign trs_bad = (fly_trs_due && (!rx_trs_seen || (rx_trs_id != fly_trs_id))) ||
                     (rx_trs_seen && !fly_trs_due);
    assign trs_good = fly_trs_due && rx_trs_seen && (rx_trs_id == fly_trs_id);

    // Error flag, set at once and held until a correct reference
    always_ff @(posedge clk) begin
        if (reset) begin
            timing_ref_error <= 1'b0;
        end else if (ce) begin
            timing_ref_error <= trs_bad ? 1'b1 : (trs_good ? 1'b0 : timing_ref_error);
        end
    end

    // ----------------------------------------
    // Line store reset pulse
    // ----------------------------------------
    logic pulse_word;

    assign pulse_word = composite ? id_word :
                        (id_word && (cur_eav == reset_position_select));

    // Active-low pulse on the chosen ID word
    always_ff @(posedge clk) begin
        if (reset) begin
            line_store_reset_n <= 1'b1;
        end else if (ce) begin
            line_store_reset_n <= !pulse_word;
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic acc;
    logic wr_done;
    logic rd_capture;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_in;
    logic hit_out;
    logic hit_sel;
    logic hit_val;
    logic hit_rin;
    logic hit_rout;
    logic mapped;
    logic [9:0] rsv_in_word;
    logic [9:0] rsv_out_word;
    logic [31:0] next_rdata;

    assign acc = psel && penable && !pready;
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_capture = acc && !pwrite;
    assign hit_ctrl = paddr == VTEDH_CTRL_ADDR;
    assign hit_stat = paddr == VTEDH_STATUS_ADDR;
    assign hit_in = paddr == VTEDH_IN_FLAGS_ADDR;
    assign hit_out = paddr == VTEDH_OUT_FLAGS_ADDR;
    assign hit_sel = paddr == VTEDH_OVR_SEL_ADDR;
    assign hit_val = paddr == VTEDH_OVR_VAL_ADDR;
    assign hit_rin = (paddr[7:5] == VTEDH_RSV_IN_BASE[7:5]) && (rsv_index(paddr) < 3'h7) && (paddr[1:0] == 2'h0);
    assign hit_rout = (paddr[7:5] == VTEDH_RSV_OUT_BASE[7:5]) && (rsv_index(paddr) < 3'h7) && (paddr[1:0] == 2'h0);
    assign mapped = hit_ctrl || hit_stat || hit_in || hit_out || hit_sel || hit_val || hit_rin || hit_rout;

    // ----------------------------------------
    // EDH flag groups
    // ----------------------------------------
    vtedh_sticky_if #(.W(VTEDH_IN_W)) in_fl ();
    vtedh_sticky_if #(.W(VTEDH_OUT_W)) out_fl ();
    logic [14:0] next_out_flags;

    assign next_out_flags = (ovr_sel & ovr_val) | (~ovr_sel & edh_calc_flags);
    // Validity stored inverted so that one sticky-high store serves it
    assign in_fl.update = edh_in_strobe;
    assign in_fl.sample = {~edh_in_apv, ~edh_in_ffv, edh_in_flags};
    assign in_fl.latch_en = ctrl[VTEDH_CTRL_IN_LATCH];
    assign in_fl.rd_clr = rd_capture && hit_in;
    assign out_fl.update = edh_out_strobe;
    assign out_fl.sample = {edh_calc_chksm_err, next_out_flags};
    assign out_fl.latch_en = ctrl[VTEDH_CTRL_OUT_LATCH];
    assign out_fl.rd_clr = rd_capture && hit_out;

    // Incoming flags and validity
    vtedh_sticky #(.W(VTEDH_IN_W)) u_in_sticky (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .fl(in_fl)
    );

    // Outgoing flags and packet checksum error
    vtedh_sticky #(.W(VTEDH_OUT_W)) u_out_sticky (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .fl(out_fl)
    );

    // Reserved word stores
    logic [9:0] edh_out_rsv_word_d;
    vtedh_rsv_store u_rsv (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .host_wr(wr_done && hit_rout),
        .host_idx(rsv_index(paddr)),
        .host_wdata(pwdata[9:0]),
        .host_in_word(rsv_in_word),
        .host_out_word(rsv_out_word),
        .in_valid(edh_in_rsv_valid),
        .in_idx(edh_in_rsv_idx),
        .in_word(edh_in_rsv_word),
        .override(ctrl[VTEDH_CTRL_RSV_OVR]),
        .out_idx(edh_out_rsv_idx),
        .out_pass(edh_out_rsv_pass),
        .out_word(edh_out_rsv_word_d)
    );

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) next_rdata = {28'h000_0000, ctrl};
        if (hit_stat) next_rdata = {27'h000_0000, composite, timing_ref_error, field_id};
        if (hit_in) next_rdata = {15'h0000, ~in_fl.held[16:15], in_fl.held[14:0]};
        if (hit_out) next_rdata = {16'h0000, out_fl.held};
        if (hit_sel) next_rdata = {17'h0_0000, ovr_sel};
        if (hit_val) next_rdata = {17'h0_0000, ovr_val};
        if (hit_rin) next_rdata = {22'h00_0000, rsv_in_word};
        if (hit_rout) next_rdata = {22'h00_0000, rsv_out_word};
    end

    // ----------------------------------------
    // APB answer, one wait state per access
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= acc;
            pslverr <= acc && !mapped;
            if (rd_capture) prdata <= next_rdata;
        end
    end

    // Host-written control
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl <= VTEDH_CTRL_RESET;
            ovr_sel <= 15'h0000;
            ovr_val <= 15'h0000;
        end else if (ce && wr_done) begin
            if (hit_ctrl) ctrl <= pwdata[3:0];
            if (hit_sel) ovr_sel <= pwdata[14:0];
            if (hit_val) ovr_val <= pwdata[14:0];
        end
    end

    // ----------------------------------------
    // EDH outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            edh_out_flags <= 15'h0000;
            edh_out_rsv_word <= 10'h000;
            edh_interrupt <= 1'b0;
        end else if (ce) begin
            if (edh_out_strobe) edh_out_flags <= next_out_flags;
            edh_out_rsv_word <= edh_out_rsv_word_d;
            edh_interrupt <= (|in_fl.held[14:0]) || (|out_fl.held);
        end
    end
endmodule : vtedh_top
`default_nettype wire

// ===== verif/vtedh_stream.sv
`timescale 1ns/1ns
`default_nettype none
module vtedh_stream (
    // Clock and run
    input wire logic clk,
    input wire logic run,
    // Position and marks
    output logic out_trs_start,
    output logic out_trs_eav,
    output logic [9:0] fly_line,
    output logic [11:0] fly_sample
);
    // Lines of 32 words, EAV and SAV marks 16 apart
    always_ff @(posedge clk) begin
        fly_sample <= run ? fly_sample + 12'h001 : 12'h000;
        out_trs_start <= run && fly_sample[3:0] == 4'hF;
        out_trs_eav <= ~fly_sample[4];
        fly_line <= !run ? 10'h014 : fly_line + {9'h000, fly_sample[4:0] == 5'h1F};
    end
endmodule : vtedh_stream
`default_nettype wire

// ===== verif/vtedh_chk.sv
`timescale 1ns/1ns
`default_nettype none
module vtedh_chk import vtedh_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Watched inputs
    input wire logic [3:0] standard_code,
    input wire logic reset_position_select,
    input wire logic [2:0] fly_field,
    input wire logic out_trs_start,
    input wire logic out_trs_eav,
    input wire logic fly_trs_due,
    input wire logic [9:0] fly_trs_id,
    input wire logic rx_trs_seen,
    input wire logic [9:0] rx_trs_id,
    // Watched outputs
    input wire logic [2:0] field_id,
    input wire logic line_blank_flag,
    input wire logic timing_ref_error,
    input wire logic line_store_reset_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Composite decode
    wire logic comp = standard_code == VTEDH_STD_NTSC_CMP || standard_code == VTEDH_STD_PAL_CMP;
    wire logic good = rx_trs_seen && rx_trs_id == fly_trs_id;
    // Timing properties
    property p_err_set; ce && fly_trs_due && !good |=> timing_ref_error; endproperty
    a_err_set: assert property (p_err_set) else $error("timing error missed");
    property p_err_hold; ce && timing_ref_error && !(fly_trs_due && rx_trs_seen) |=> timing_ref_error; endproperty
    a_err_hold: assert property (p_err_hold) else $error("timing error dropped");
    property p_lsr; $fell(line_store_reset_n) |=> line_store_reset_n; endproperty
    a_lsr: assert property (p_lsr) else $error("reset pulse too long");
    property p_lsr_comp; !comp && out_trs_start && out_trs_eav && reset_position_select |-> ##4 !line_store_reset_n; endproperty
    a_lsr_comp: assert property (p_lsr_comp) else $error("no pulse on EAV");
    property p_lsr_cmpst; comp && out_trs_start |-> ##5 !line_store_reset_n; endproperty
    a_lsr_cmpst: assert property (p_lsr_cmpst) else $error("no composite pulse");
    property p_blank_comp; !comp && out_trs_start |=> line_blank_flag; endproperty
    a_blank_comp: assert property (p_blank_comp) else $error("blank low in TRS");
    property p_blank_cmpst; comp && out_trs_start |=> line_blank_flag [*5] ##1 !line_blank_flag; endproperty
    a_blank_cmpst: assert property (p_blank_cmpst) else $error("composite blank span");
    property p_field; ce |=> field_id == ($past(comp) ? $past(fly_field) : {2'b00, $past(fly_field[0])}); endproperty
    a_field: assert property (p_field) else $error("field wrong");
endmodule : vtedh_chk
bind vtedh_top vtedh_chk chk (.*);
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import vtedh_pkg::*;
    // Design signals
    logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, err, run, blanking_length_select;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [3:0] standard_code;
    logic [2:0] fly_field, field_id, edh_in_rsv_idx, edh_out_rsv_idx;
    logic [9:0] fly_line, fly_trs_id, rx_trs_id, edh_in_rsv_word, edh_out_rsv_pass, edh_out_rsv_word;
    logic [11:0] fly_sample;
    logic [14:0] edh_in_flags, edh_calc_flags, edh_out_flags;
    logic out_trs_start, out_trs_eav, fly_trs_due, rx_trs_seen, edh_in_strobe, edh_in_ffv, edh_in_apv;
    logic edh_in_rsv_valid, edh_out_strobe, edh_calc_chksm_err, frame_blanking_flag, line_blank_flag;
    logic timing_ref_error, line_store_reset_n, edh_interrupt, reset_position_select;
    int error_cnt, samples_checked, cyc, seed;
    vtedh_top dut (.*);
    vtedh_stream far (.*);
    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer, result in q and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fly_field, fly_trs_due, fly_trs_id, rx_trs_seen, rx_trs_id} = '0;
        {edh_in_strobe, edh_in_flags, edh_in_ffv, edh_in_apv, edh_in_rsv_valid, edh_in_rsv_idx} = '0;
        {edh_in_rsv_word, edh_out_strobe, edh_calc_flags, edh_calc_chksm_err, edh_out_rsv_idx} = '0;
        {edh_out_rsv_pass, blanking_length_select, run, reset, ce, reset_position_select} = 15'h0007;
        standard_code = 4'h4;
        seed = 83808;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, VTEDH_CTRL_ADDR, 32'h0);
        chk(q, 32'h0000_0001);
        apb(1'b0, 8'hFC, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, VTEDH_CTRL_ADDR, 32'h0000_000E);
        r = $random(seed);
        r[0] = 1'b1;
        fly_field <= r[2:0];
        {edh_in_strobe, edh_in_flags, edh_in_ffv, edh_in_apv} <= {1'b1, r[14:0], 2'b01};
        @(posedge clk);
        {edh_in_flags, edh_in_ffv, edh_in_apv} <= {15'h0000, 2'b11};
        @(posedge clk);
        edh_in_strobe <= 1'b0;
        repeat (2) @(posedge clk);
        chk(edh_interrupt, 1'b1);
        apb(1'b0, VTEDH_IN_FLAGS_ADDR, 32'h0);
        chk(q, {15'h0000, 2'b10, r[14:0]});
        apb(1'b0, VTEDH_IN_FLAGS_ADDR, 32'h0);
        chk(q, 32'h0001_8000);
        apb(1'b1, VTEDH_OVR_SEL_ADDR, {17'h0_0000, r[29:15]});
        apb(1'b1, VTEDH_OVR_VAL_ADDR, {17'h0_0000, r[31:17]});
        {edh_out_strobe, edh_calc_flags} <= {1'b1, r[16:2]};
        @(posedge clk);
        edh_out_strobe <= 1'b0;
        @(posedge clk);
        chk(edh_out_flags, r[16:2] & ~r[29:15] | r[31:17] & r[29:15]);
        apb(1'b0, VTEDH_OUT_FLAGS_ADDR, 32'h0);
        chk(q, {17'h0_0000, r[16:2] & ~r[29:15] | r[31:17] & r[29:15]});
        apb(1'b1, VTEDH_RSV_OUT_BASE + 8'h08, {22'h00_0000, r[9:0]});
        {edh_out_rsv_idx, edh_out_rsv_pass} <= {3'h2, ~r[9:0]};
        {edh_in_rsv_valid, edh_in_rsv_idx, edh_in_rsv_word} <= {1'b1, 3'h5, r[19:10]};
        @(posedge clk);
        edh_in_rsv_valid <= 1'b0;
        @(posedge clk);
        chk(edh_out_rsv_word, r[9:0]);
        apb(1'b0, VTEDH_RSV_IN_BASE + 8'h14, 32'h0);
        chk(q, r[19:10]);
        fly_trs_due <= 1'b1;
        @(posedge clk);
        fly_trs_due <= 1'b0;
        apb(1'b0, VTEDH_STATUS_ADDR, 32'h0);
        chk(q[3], 1'b1);
        {fly_trs_due, rx_trs_seen, fly_trs_id, rx_trs_id} <= {2'b11, r[9:0], r[9:0]};
        @(posedge clk);
        {fly_trs_due, rx_trs_seen} <= 2'b00;
        @(posedge clk);
        chk(timing_ref_error, 1'b0);
        run <= 1'b1;
        while (fly_line != 10'h015) @(posedge clk);
        chk(frame_blanking_flag, 1'b1);
        while (fly_line != 10'h017) @(posedge clk);
        repeat (20) @(posedge clk);
        chk(frame_blanking_flag, 1'b0);
        run <= 1'b0;
        repeat (8) @(posedge clk);
        {standard_code, reset_position_select, run} <= {VTEDH_STD_PAL_CMP, 2'b01};
        repeat (200) @(posedge clk);
        apb(1'b0, VTEDH_STATUS_ADDR, 32'h0);
        chk(q[4], 1'b1);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
